// ==== design/tmc_pkg.sv ====
// constants shared by the timer output compare block
package tmc_pkg;

    // register byte offsets on the wishbone bus
    localparam logic [5:0] TMC_CTRL_OFS = 6'h00;
    localparam logic [5:0] TMC_FORCE_OFS = 6'h04;
    localparam logic [5:0] TMC_STATUS_OFS = 6'h08;
    localparam logic [5:0] TMC_COUNT_LO_OFS = 6'h0C;
    localparam logic [5:0] TMC_COUNT_HI_OFS = 6'h10;
    localparam logic [5:0] TMC_MATCH_A_LO_OFS = 6'h14;
    localparam logic [5:0] TMC_MATCH_A_HI_OFS = 6'h18;
    localparam logic [5:0] TMC_MATCH_B_LO_OFS = 6'h1C;
    localparam logic [5:0] TMC_MATCH_B_HI_OFS = 6'h20;
    localparam logic [5:0] TMC_CAPTURE_LO_OFS = 6'h24;
    localparam logic [5:0] TMC_CAPTURE_HI_OFS = 6'h28;

    // control register field positions
    localparam int TMC_CTRL_MODE_LSB = 0;
    localparam int TMC_CTRL_ACT_A_LSB = 4;
    localparam int TMC_CTRL_ACT_B_LSB = 6;
    localparam int TMC_CTRL_IEN_LSB = 8;
    // status register field positions
    localparam int TMC_STAT_FLAG_LSB = 0;
    localparam int TMC_STAT_LATCH_LSB = 2;

    // waveform_mode_sel codes
    localparam logic [3:0] TMC_MODE_NORMAL = 4'h0;
    localparam logic [3:0] TMC_MODE_PC8 = 4'h1;
    localparam logic [3:0] TMC_MODE_PC9 = 4'h2;
    localparam logic [3:0] TMC_MODE_PC10 = 4'h3;
    localparam logic [3:0] TMC_MODE_CTC_A = 4'h4;
    localparam logic [3:0] TMC_MODE_FAST8 = 4'h5;
    localparam logic [3:0] TMC_MODE_FAST9 = 4'h6;
    localparam logic [3:0] TMC_MODE_FAST10 = 4'h7;
    localparam logic [3:0] TMC_MODE_PFC_CAP = 4'h8;
    localparam logic [3:0] TMC_MODE_PFC_A = 4'h9;
    localparam logic [3:0] TMC_MODE_PC_CAP = 4'hA;
    localparam logic [3:0] TMC_MODE_PC_A = 4'hB;
    localparam logic [3:0] TMC_MODE_CTC_CAP = 4'hC;
    localparam logic [3:0] TMC_MODE_RSVD = 4'hD;
    localparam logic [3:0] TMC_MODE_FAST_CAP = 4'hE;
    localparam logic [3:0] TMC_MODE_FAST_A = 4'hF;

    // output_action_sel codes
    localparam logic [1:0] TMC_ACT_NONE = 2'h0;
    localparam logic [1:0] TMC_ACT_TOGGLE = 2'h1;
    localparam logic [1:0] TMC_ACT_CLEAR = 2'h2;
    localparam logic [1:0] TMC_ACT_SET = 2'h3;

    // fixed counter limits
    localparam logic [15:0] TMC_MAX = 16'hFFFF;
    localparam logic [15:0] TMC_BOTTOM = 16'h0000;
    localparam logic [15:0] TMC_TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TMC_TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TMC_TOP_10BIT = 16'h03FF;

    // reset values
    localparam logic [15:0] TMC_RST_WORD = 16'h0000;
    localparam logic [7:0] TMC_RST_BYTE = 8'h00;

    // all state of the block
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [15:0] count_value;
        logic count_down;
        logic match_block;
        logic [7:0] temp_high;
        logic [3:0] waveform_mode_sel;
        logic [1:0][1:0] output_action_sel;
        logic [1:0] match_irq_enable;
        logic [1:0] match_flag;
        logic [1:0] match_output_latch;
        logic [1:0][15:0] match_buf;
        logic [1:0][15:0] match_value_reg;
        logic [15:0] capture_value_reg;
    } tmc_state_t;

endpackage : tmc_pkg

// ==== design/tmc_timer_compare.sv ====
// output compare channels a and b of a 16-bit timer with wishbone registers
`timescale 1ns/10ps

module tmc_timer_compare
    import tmc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic timer_tick_i,
    input wire logic [1:0] irq_ack_i,
    output logic [1:0] irq_o,
    input wire logic [1:0] port_out_i,
    input wire logic [1:0] pin_direction_bit_i,
    output logic [1:0] pin_o,
    output logic [1:0] pin_oe_o,
    output logic [15:0] count_value_o
);

    tmc_state_t st_r;
    tmc_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // mode decode

    logic pwm_mode;
    logic dual_slope;
    logic variable_top;
    logic update_at_bottom;
    logic [15:0] top_value;

    always_comb begin
        pwm_mode = 1'b1;
        dual_slope = 1'b0;
        variable_top = 1'b0;
        update_at_bottom = 1'b0;
        top_value = TMC_MAX;
        unique case (st_r.waveform_mode_sel)
            TMC_MODE_NORMAL: begin
                pwm_mode = 1'b0;
            end
            TMC_MODE_CTC_A: begin
                pwm_mode = 1'b0;
                variable_top = 1'b1;
                top_value = st_r.match_value_reg[0];
            end
            TMC_MODE_CTC_CAP: begin
                pwm_mode = 1'b0;
                variable_top = 1'b1;
                top_value = st_r.capture_value_reg;
            end
            TMC_MODE_RSVD: begin
                pwm_mode = 1'b0;
            end
            TMC_MODE_PC8: begin
                dual_slope = 1'b1;
                top_value = TMC_TOP_8BIT;
            end
            TMC_MODE_PC9: begin
                dual_slope = 1'b1;
                top_value = TMC_TOP_9BIT;
            end
            TMC_MODE_PC10: begin
                dual_slope = 1'b1;
                top_value = TMC_TOP_10BIT;
            end
            TMC_MODE_FAST8: begin
                top_value = TMC_TOP_8BIT;
            end
            TMC_MODE_FAST9: begin
                top_value = TMC_TOP_9BIT;
            end
            TMC_MODE_FAST10: begin
                top_value = TMC_TOP_10BIT;
            end
            TMC_MODE_PFC_CAP, TMC_MODE_PC_CAP, TMC_MODE_FAST_CAP: begin
                dual_slope = (st_r.waveform_mode_sel != TMC_MODE_FAST_CAP);
                update_at_bottom =
                    (st_r.waveform_mode_sel == TMC_MODE_PFC_CAP);
                variable_top = 1'b1;
                top_value = st_r.capture_value_reg;
            end
            TMC_MODE_PFC_A, TMC_MODE_PC_A, TMC_MODE_FAST_A: begin
                dual_slope = (st_r.waveform_mode_sel != TMC_MODE_FAST_A);
                update_at_bottom = (st_r.waveform_mode_sel == TMC_MODE_PFC_A);
                variable_top = 1'b1;
                top_value = st_r.match_value_reg[0];
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    logic bus_req;
    logic wr_en;
    logic rd_en;
    logic [7:0] wr_byte;

    assign bus_req = cyc_i && stb_i && !st_r.ack;
    assign wr_en = bus_req && we_i && sel_i[0];
    assign rd_en = bus_req && !we_i;
    assign wr_byte = dat_i[7:0];

    ////////////////////////////////////////////////////////////////////////
    // next state

    logic count_write;
    logic at_top;
    logic at_bottom;
    logic [1:0] hit;
    logic [1:0] next_latch;
    logic [1:0] act;
    logic [15:0] full_word;

    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = bus_req;
        full_word = {st_r.temp_high, wr_byte};
        count_write = wr_en && (adr_i == TMC_COUNT_LO_OFS);
        // variable top written by software is not honoured while blocked
        at_top = (st_r.count_value == top_value)
            && !(variable_top && st_r.match_block);
        at_bottom = (st_r.count_value == TMC_BOTTOM);
        next_latch = st_r.match_output_latch;
        act = 2'b00;

        // comparators and waveform actions
        for (int ch = 0; ch < 2; ch++) begin
            hit[ch] = (st_r.count_value == st_r.match_value_reg[ch])
                && !st_r.match_block;
            act = st_r.output_action_sel[ch];
            if (timer_tick_i && hit[ch]) begin
                st_nxt.match_flag[ch] = 1'b1;
                if (!pwm_mode) begin
                    unique case (act)
                        TMC_ACT_NONE: next_latch[ch] = next_latch[ch];
                        TMC_ACT_TOGGLE: next_latch[ch] = !next_latch[ch];
                        TMC_ACT_CLEAR: next_latch[ch] = 1'b0;
                        TMC_ACT_SET: next_latch[ch] = 1'b1;
                    endcase
                end else if (act[1]) begin
                    // dual slope mirrors the action on the way down
                    next_latch[ch] = act[0] ^ (dual_slope && st_r.count_down);
                end
            end
            // fast pwm restarts the pulse at bottom
            if (timer_tick_i && pwm_mode && !dual_slope && at_top
                && act[1]) begin
                next_latch[ch] = !act[0];
            end
        end

        // interrupt service and software clear, hardware set wins
        for (int ch = 0; ch < 2; ch++) begin
            if (!(timer_tick_i && hit[ch])) begin
                if (irq_ack_i[ch]) begin
                    st_nxt.match_flag[ch] = 1'b0;
                end
                if (wr_en && adr_i == TMC_STATUS_OFS
                    && wr_byte[TMC_STAT_FLAG_LSB + ch]) begin
                    st_nxt.match_flag[ch] = 1'b0;
                end
            end
        end

        // force strobe, non-pwm only, latch only
        if (wr_en && adr_i == TMC_FORCE_OFS && !pwm_mode) begin
            for (int ch = 0; ch < 2; ch++) begin
                if (wr_byte[ch]) begin
                    unique case (st_r.output_action_sel[ch])
                        TMC_ACT_NONE: next_latch[ch] = next_latch[ch];
                        TMC_ACT_TOGGLE: next_latch[ch] = !next_latch[ch];
                        TMC_ACT_CLEAR: next_latch[ch] = 1'b0;
                        TMC_ACT_SET: next_latch[ch] = 1'b1;
                    endcase
                end
            end
        end
        // latch untouched by mode changes
        st_nxt.match_output_latch = next_latch;

        // counter sequencing
        if (timer_tick_i) begin
            st_nxt.match_block = 1'b0;
            if (!dual_slope) begin
                if (at_top) begin
                    st_nxt.count_value = TMC_BOTTOM;
                end else begin
                    st_nxt.count_value = st_r.count_value + 16'h0001;
                end
            end else if (!st_r.count_down) begin
                if (at_top) begin
                    st_nxt.count_down = 1'b1;
                    st_nxt.count_value = st_r.count_value - 16'h0001;
                end else begin
                    st_nxt.count_value = st_r.count_value + 16'h0001;
                end
            end else if (at_bottom) begin
                st_nxt.count_down = 1'b0;
                st_nxt.count_value = st_r.count_value + 16'h0001;
            end else begin
                st_nxt.count_value = st_r.count_value - 16'h0001;
            end
            // buffered compare values move only at top or bottom
            if (pwm_mode && ((update_at_bottom && at_bottom)
                || (!update_at_bottom && at_top))) begin
                st_nxt.match_value_reg = st_r.match_buf;
            end
        end
        if (!dual_slope) begin
            st_nxt.count_down = 1'b0;
        end

        // software writes, counter write overrides counting
        if (count_write) begin
            st_nxt.count_value = full_word;
            st_nxt.match_block = 1'b1;
        end
        if (wr_en) begin
            unique case (adr_i)
                TMC_CTRL_OFS: begin
                    st_nxt.waveform_mode_sel =
                        dat_i[TMC_CTRL_MODE_LSB +: 4];
                    // action bits are live, never buffered
                    st_nxt.output_action_sel[0] =
                        dat_i[TMC_CTRL_ACT_A_LSB +: 2];
                    st_nxt.output_action_sel[1] =
                        dat_i[TMC_CTRL_ACT_B_LSB +: 2];
                    if (sel_i[1]) begin
                        st_nxt.match_irq_enable =
                            dat_i[TMC_CTRL_IEN_LSB +: 2];
                    end
                end
                TMC_COUNT_HI_OFS, TMC_MATCH_A_HI_OFS, TMC_MATCH_B_HI_OFS,
                TMC_CAPTURE_HI_OFS: begin
                    st_nxt.temp_high = wr_byte;
                end
                TMC_MATCH_A_LO_OFS: begin
                    st_nxt.match_buf[0] = full_word;
                    if (!pwm_mode) begin
                        st_nxt.match_value_reg[0] = full_word;
                    end
                end
                TMC_MATCH_B_LO_OFS: begin
                    st_nxt.match_buf[1] = full_word;
                    if (!pwm_mode) begin
                        st_nxt.match_value_reg[1] = full_word;
                    end
                end
                TMC_CAPTURE_LO_OFS: begin
                    st_nxt.capture_value_reg = full_word;
                end
                default: begin
                    st_nxt.temp_high = st_r.temp_high;
                end
            endcase
        end

        // read data, unmapped offsets read zero
        st_nxt.rdata = 32'h0000_0000;
        if (rd_en) begin
            unique case (adr_i)
                TMC_CTRL_OFS: begin
                    st_nxt.rdata[TMC_CTRL_MODE_LSB +: 4] =
                        st_r.waveform_mode_sel;
                    st_nxt.rdata[TMC_CTRL_ACT_A_LSB +: 2] =
                        st_r.output_action_sel[0];
                    st_nxt.rdata[TMC_CTRL_ACT_B_LSB +: 2] =
                        st_r.output_action_sel[1];
                    st_nxt.rdata[TMC_CTRL_IEN_LSB +: 2] =
                        st_r.match_irq_enable;
                end
                TMC_STATUS_OFS: begin
                    st_nxt.rdata[TMC_STAT_FLAG_LSB +: 2] = st_r.match_flag;
                    st_nxt.rdata[TMC_STAT_LATCH_LSB +: 2] =
                        st_r.match_output_latch;
                end
                TMC_COUNT_LO_OFS: begin
                    st_nxt.rdata[7:0] = st_r.count_value[7:0];
                    st_nxt.temp_high = st_r.count_value[15:8];
                end
                TMC_COUNT_HI_OFS: begin
                    st_nxt.rdata[7:0] = st_r.temp_high;
                end
                TMC_MATCH_A_LO_OFS: begin
                    st_nxt.rdata[7:0] = st_r.match_buf[0][7:0];
                end
                TMC_MATCH_A_HI_OFS: begin
                    st_nxt.rdata[7:0] = st_r.match_buf[0][15:8];
                end
                TMC_MATCH_B_LO_OFS: begin
                    st_nxt.rdata[7:0] = st_r.match_buf[1][7:0];
                end
                TMC_MATCH_B_HI_OFS: begin
                    st_nxt.rdata[7:0] = st_r.match_buf[1][15:8];
                end
                TMC_CAPTURE_LO_OFS: begin
                    st_nxt.rdata[7:0] = st_r.capture_value_reg[7:0];
                    st_nxt.temp_high = st_r.capture_value_reg[15:8];
                end
                TMC_CAPTURE_HI_OFS: begin
                    st_nxt.rdata[7:0] = st_r.temp_high;
                end
                default: begin
                    st_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign ack_o = st_r.ack;
    assign dat_o = st_r.rdata;
    assign count_value_o = st_r.count_value;
    assign irq_o = st_r.match_flag & st_r.match_irq_enable;

    // capture is a plain register here; action bits never reach it
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_pin
            assign pin_o[ch] = (st_r.output_action_sel[ch] != TMC_ACT_NONE)
                ? st_r.match_output_latch[ch] : port_out_i[ch];
            assign pin_oe_o[ch] = pin_direction_bit_i[ch];
        end
    endgenerate

endmodule : tmc_timer_compare

// ==== tb/tmc_port_model.sv ====
// port pin model standing beyond the compare outputs
`timescale 1ns/10ps
module tmc_port_model (
    input wire logic clk_i,
    input wire logic [1:0] val_set_i,
    input wire logic [1:0] dir_set_i,
    input wire logic [1:0] pin_i,
    input wire logic [1:0] oe_i,
    output logic [1:0] port_out_o,
    output logic [1:0] dir_o,
    output logic [1:0] pad_o
);
    // port registers load one clock after software asks
    always @(posedge clk_i) begin
        port_out_o <= val_set_i;
        dir_o <= dir_set_i;
    end
    // undriven pad settles at the pull-up level, never at the old value
    assign pad_o = (oe_i & pin_i) | ~oe_i;
endmodule : tmc_port_model

// ==== tb/tmc_chk_sva.sv ====
// concurrent checks on the compare block ports
`timescale 1ns/10ps
module tmc_chk
    import tmc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    input wire logic timer_tick_i,
    input wire logic [1:0] irq_ack_i,
    input wire logic [1:0] irq_o,
    input wire logic [1:0] pin_direction_bit_i,
    input wire logic [1:0] pin_oe_o,
    input wire logic [15:0] count_value_o
);
    ////////////////////////////////////////
    // shadow of channel a, valid in normal mode only (writes go direct)
    logic wr_s, cnt_wr, st_wr, ma_hit, blk_r, ien_r;
    logic [7:0] tmp_r;
    logic [15:0] ma_r;
    logic [3:0] mode_r;
    assign wr_s = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
    assign cnt_wr = wr_s && adr_i == TMC_COUNT_LO_OFS;
    assign st_wr = wr_s && adr_i == TMC_STATUS_OFS && mode_r == 4'h0;
    assign ma_hit = timer_tick_i && !blk_r && mode_r == 4'h0
        && count_value_o == ma_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blk_r <= 1'h0;
            ien_r <= 1'h0;
            tmp_r <= 8'h00;
            ma_r <= 16'h0000;
            mode_r <= 4'h0;
        end else begin
            blk_r <= cnt_wr ? 1'h1 : (timer_tick_i ? 1'h0 : blk_r);
            if (wr_s && adr_i >= 6'h10 && !adr_i[2]) tmp_r <= dat_i[7:0];
            if (wr_s && adr_i == TMC_MATCH_A_LO_OFS)
                ma_r <= {tmp_r, dat_i[7:0]};
            if (wr_s && adr_i == TMC_CTRL_OFS) mode_r <= dat_i[3:0];
            if (wr_s && sel_i[1] && adr_i == TMC_CTRL_OFS) ien_r <= dat_i[8];
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence ans_s;
        ack_o ##1 !ack_o;
    endsequence
    chk_ack_pulse: assert property (req_s |=> ans_s)
        else $error("bus answer not a single pulse");
    chk_reset_clear: assert property (
        $fell(rst_i) |-> count_value_o == 16'h0 && irq_o == 2'h0 && !ack_o)
        else $error("state not cleared by reset");
    chk_pin_dir: assert property (pin_oe_o == pin_direction_bit_i)
        else $error("pin direction not from port");
    chk_count_hold: assert property (
        !timer_tick_i && !cnt_wr |=> $stable(count_value_o))
        else $error("counter moved without tick");
    chk_normal_count: assert property (
        timer_tick_i && mode_r == 4'h0 && !cnt_wr
        |=> count_value_o == $past(count_value_o) + 16'h1)
        else $error("normal mode count wrong");
    chk_match_irq: assert property (
        ma_hit && ien_r && !wr_s |=> irq_o[0])
        else $error("match did not raise request");
    chk_match_block: assert property (
        timer_tick_i && blk_r && !wr_s && count_value_o == ma_r
        && mode_r == 4'h0 && !irq_o[0] |=> !irq_o[0])
        else $error("blocked match raised request");
    chk_irq_ack: assert property (
        irq_ack_i[0] && !ma_hit && !wr_s && mode_r == 4'h0 |=> !irq_o[0])
        else $error("serviced request not cleared");
    chk_flag_w1c: assert property (
        st_wr && dat_i[0] && !ma_hit |=> !irq_o[0])
        else $error("write one did not clear flag");
    chk_flag_w0: assert property (
        st_wr && !dat_i[0] && irq_o[0] && !irq_ack_i[0] |=> irq_o[0])
        else $error("write zero cleared flag");
endmodule : tmc_chk

// ==== tb/testbench.sv ====
// self-checking bench for the timer output compare block
`timescale 1ns/10ps
module testbench
    import tmc_pkg::*;
;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, timer_tick_i;
    logic [5:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [15:0] count_value_o;
    logic [1:0] irq_ack_i, irq_o, port_out_i, pin_direction_bit_i;
    logic [1:0] pin_o, pin_oe_o, val_set, dir_set, pad;
    logic [1:0] act_tab [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
    logic latch_tab [4] = '{1'h0, 1'h1, 1'h1, 1'h1};
    int failures = 0;
    int samples_checked = 0;

    tmc_timer_compare dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i, .dat_i, .dat_o, .ack_o, .timer_tick_i, .irq_ack_i, .irq_o,
        .port_out_i, .pin_direction_bit_i, .pin_o, .pin_oe_o, .count_value_o);
    tmc_port_model port (.clk_i, .val_set_i(val_set), .dir_set_i(dir_set),
        .pin_i(pin_o), .oe_i(pin_oe_o), .port_out_o(port_out_i),
        .dir_o(pin_direction_bit_i), .pad_o(pad));

    initial begin
        clk_i = 1'h0;
        forever #2.5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask : check

    task automatic final_report;
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    // one classic cycle; request held until ack is seen at an edge
    // no own limit: only the watchdog ends a hung wait
    task automatic bus(input logic w, input logic [5:0] a,
        input logic [31:0] d);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'h1);
        rd = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        we_i <= 1'h0;
        @(posedge clk_i);
    endtask : bus

    // high byte first: it only reaches the shared latch
    task automatic wr16(input logic [5:0] lo, input logic [15:0] d);
        bus(1'h1, lo + 6'h04, {24'h0, d[15:8]});
        bus(1'h1, lo, {24'h0, d[7:0]});
    endtask : wr16

    task automatic ticks(input int n);
        repeat (n) begin
            timer_tick_i <= 1'h1;
            @(posedge clk_i);
        end
        timer_tick_i <= 1'h0;
        @(posedge clk_i);
    endtask : ticks
    ////////////////////////////////////////
    initial begin
        #100000;
        failures++;
        final_report();
    end

    initial begin
        {rst_i, sel_i} = 5'h1F;
        {cyc_i, stb_i, we_i, timer_tick_i} = 4'h0;
        {adr_i, dat_i, irq_ack_i, val_set, dir_set} = 44'h0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        bus(1'h0, TMC_CTRL_OFS, 32'h0);
        check(rd, 32'h0);
        bus(1'h0, TMC_STATUS_OFS, 32'h0);
        check(rd, 32'h0);
        bus(1'h0, 6'h3C, 32'h0);
        check(rd, 32'h0);
        wr16(TMC_MATCH_A_LO_OFS, 16'h0007);
        wr16(TMC_MATCH_B_LO_OFS, 16'hA55A);
        bus(1'h0, TMC_COUNT_LO_OFS, 32'h0);
        bus(1'h0, TMC_MATCH_B_HI_OFS, 32'h0);
        check(rd, 32'hA5);
        bus(1'h1, TMC_MATCH_B_HI_OFS, 32'h12);
        bus(1'h0, TMC_MATCH_B_LO_OFS, 32'h0);
        check(rd, 32'h5A);
        bus(1'h1, TMC_MATCH_B_LO_OFS, 32'h34);
        bus(1'h0, TMC_MATCH_B_HI_OFS, 32'h0);
        check(rd, 32'h12);
        // normal mode, toggle on a, request enabled
        bus(1'h1, TMC_CTRL_OFS, 32'h110);
        wr16(TMC_COUNT_LO_OFS, 16'h0005);
        ticks(2);
        check(irq_o, 2'h0);
        ticks(1);
        check(irq_o, 2'h1);
        check(count_value_o, 16'h8);
        bus(1'h0, TMC_STATUS_OFS, 32'h0);
        check(rd, 32'h5);
        check(pin_oe_o, 2'h0);
        val_set <= 2'h2;
        dir_set <= 2'h3;
        repeat (2) @(posedge clk_i);
        check(pad, 2'h3);
        wr16(TMC_COUNT_LO_OFS, 16'h0006);
        ticks(2);
        irq_ack_i <= 2'h1;
        @(posedge clk_i);
        irq_ack_i <= 2'h0;
        @(posedge clk_i);
        check(irq_o, 2'h0);
        // tick match and service in the same cycle
        wr16(TMC_COUNT_LO_OFS, 16'h0006);
        ticks(1);
        timer_tick_i <= 1'h1;
        irq_ack_i <= 2'h1;
        @(posedge clk_i);
        timer_tick_i <= 1'h0;
        irq_ack_i <= 2'h0;
        @(posedge clk_i);
        check(irq_o, 2'h1);
        bus(1'h1, TMC_STATUS_OFS, 32'h0);
        check(irq_o, 2'h1);
        bus(1'h1, TMC_STATUS_OFS, 32'h1);
        check(irq_o, 2'h0);
        wr16(TMC_COUNT_LO_OFS, 16'h0007);
        ticks(1);
        check(irq_o, 2'h0);
        wr16(TMC_CAPTURE_LO_OFS, 16'h0123);
        for (int i = 0; i < 4; i++) begin
            bus(1'h1, TMC_CTRL_OFS, {26'h0, act_tab[i], 4'h0});
            bus(1'h1, TMC_FORCE_OFS, 32'h1);
            bus(1'h0, TMC_STATUS_OFS, 32'h0);
            check(rd, {29'h0, latch_tab[i], 2'h0});
            check(count_value_o, 16'h8);
        end
        check(pad, 2'h2);
        bus(1'h0, TMC_CAPTURE_LO_OFS, 32'h0);
        check(rd, 32'h23);
        bus(1'h0, TMC_CAPTURE_HI_OFS, 32'h0);
        check(rd, 32'h01);
        // clear-on-match with a as top, no output action
        bus(1'h1, TMC_CTRL_OFS, 32'h4);
        bus(1'h0, TMC_STATUS_OFS, 32'h0);
        check(rd, 32'h4);
        wr16(TMC_COUNT_LO_OFS, 16'h0000);
        ticks(8);
        check(count_value_o, 16'h0);
        bus(1'h0, TMC_STATUS_OFS, 32'h0);
        check(rd, 32'h5);
        bus(1'h1, TMC_STATUS_OFS, 32'h1);
        // fast pwm with a as top: new top waits for the old top
        bus(1'h1, TMC_CTRL_OFS, 32'hF);
        wr16(TMC_MATCH_A_LO_OFS, 16'h0003);
        bus(1'h0, TMC_MATCH_A_LO_OFS, 32'h0);
        check(rd, 32'h3);
        ticks(7);
        check(count_value_o, 16'h7);
        ticks(5);
        check(count_value_o, 16'h0);
        wr16(TMC_COUNT_LO_OFS, 16'h0003);
        ticks(1);
        check(count_value_o, 16'h4);
        final_report();
    end
endmodule : testbench

bind tmc_timer_compare tmc_chk chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .ack_o, .timer_tick_i, .irq_ack_i, .irq_o,
    .pin_direction_bit_i, .pin_oe_o, .count_value_o);
